// [bench/flame_bank_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flame_bank_map.vh"
// Port-level checks; word pointer and function are tracked per request
module flame_bank_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic        req_front_port,
  input wire logic [7:0]  req_function,
  input wire logic [15:0] req_addr,
  input wire logic [2:0]  req_count,
  input wire logic        wdata_valid,
  input wire logic [15:0] wdata,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_exception,
  input wire logic        rdata_valid,
  input wire logic [15:0] rdata,
  input wire logic        busy,
  input wire logic [2:0]  active_primary,
  input wire logic [15:0] error_code
);
  logic [15:0] addr_q;
  logic [7:0]  fn_q;
  logic        front_q;
  logic        take;
  assign take = req_valid && !busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pointer steps with each read word so data maps to its register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= 16'h0000;
      fn_q <= 8'h00;
      front_q <= 1'b0;
    end else if (take) begin
      addr_q <= req_addr;
      fn_q <= req_function;
      front_q <= req_front_port;
    end else if (rdata_valid) begin
      addr_q <= addr_q + 16'h0001;
    end
  end
  a_accept_answer: assert property (take |=> busy || rsp_valid)
    else $error("request left without reaction");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_bad_function: assert property (take && req_function != 8'h03 &&
    req_function != 8'h06 && req_function != 8'h10
    |=> rsp_valid && rsp_exception == `EXC_FUNCTION)
    else $error("unsupported function not refused");
  a_multi_count: assert property (take && req_function == 8'h10 &&
    (req_count == 3'h0 || req_count > `MULTI_MAX)
    |=> rsp_valid && rsp_exception == `EXC_VALUE)
    else $error("bad multiple count not refused");
  a_read_first: assert property (take && req_function == 8'h03
    |-> ##2 rdata_valid)
    else $error("read word late");
  a_write_done: assert property (busy && wdata_valid && fn_q == 8'h06
    |=> rsp_valid) else $error("single write not answered");
  a_head_bits: assert property (rdata_valid && addr_q >= `REG_A_HEAD &&
    addr_q <= `REG_C_HEAD |-> (rdata & ~`HEAD_SEL_MASK) == 16'h0000)
    else $error("head register reserved bits set");
  a_gain_limit: assert property (rdata_valid && addr_q >= `REG_A_GAIN &&
    addr_q <= `REG_C_GAIN |-> rdata <= `GAIN_MAX)
    else $error("gain above limit");
  a_alarm_limit: assert property (rdata_valid && addr_q >= `REG_A_ALARM &&
    addr_q <= `REG_C_ALARM |-> rdata <= `ALARM_MAX)
    else $error("alarm level above limit");
  a_error_track: assert property (rsp_valid && !front_q
    |=> error_code == {8'h00, rsp_exception})
    else $error("error code not following four-wire result");
endmodule
bind flame_channel_modbus_register_bank flame_bank_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
  .req_front_port(req_front_port), .req_function(req_function),
  .req_addr(req_addr), .req_count(req_count), .wdata_valid(wdata_valid),
  .wdata(wdata), .rsp_valid(rsp_valid), .rsp_exception(rsp_exception),
  .rdata_valid(rdata_valid), .rdata(rdata), .busy(busy),
  .active_primary(active_primary), .error_code(error_code));
`default_nettype wire

// [bench/modbus_master.sv]
`timescale 1ns/1ps
`default_nettype none
// Master side: one transaction at a time, words optionally stalled
module modbus_master (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_exception,
  input  wire logic        rdata_valid,
  input  wire logic [15:0] rdata,
  output var  logic        req_valid,
  output var  logic        req_front_port,
  output var  logic [7:0]  req_function,
  output var  logic [15:0] req_addr,
  output var  logic [2:0]  req_count,
  output var  logic        wdata_valid,
  output var  logic [15:0] wdata
);
  initial begin
    {req_valid, req_front_port, req_function, req_addr, req_count} = '0;
    {wdata_valid, wdata} = '0;
  end
  // Factory key and function codes come from the caller
  task automatic xfer(input logic f, input logic [7:0] fn,
    input logic [15:0] a, input logic [2:0] n, input logic [79:0] w,
    input logic slow, output logic [7:0] exc, output logic [79:0] rd);
    int k;
    int nw;
    nw = (fn == 8'h06) ? 1 : (fn == 8'h10) ? int'(n) : 0;
    rd = '0;
    exc = 8'hff;
    @(posedge clk);
    {req_valid, req_front_port, req_function, req_addr} <= {1'b1, f, fn, a};
    req_count <= n;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~a; // Unqualified address and data lines never show the last value
    for (k = 0; k < nw; k++) begin
      wdata_valid <= 1'b1;
      wdata <= w[16*(k%5) +: 16];
      @(posedge clk);
      // An oversize write is refused while its words are still going
      if (rsp_valid) exc = rsp_exception;
      if (slow || k == nw - 1) begin
        wdata_valid <= 1'b0;
        wdata <= ~wdata;
        if (k < nw - 1) @(posedge clk);
      end
    end
    k = 0;
    // Bounded wait; a missing answer leaves exc at ff
    if (exc == 8'hff) repeat (40) begin
      @(posedge clk);
      if (rdata_valid && k < 5) begin
        rd[16*k +: 16] = rdata;
        k++;
      end
      if (rsp_valid) begin
        exc = rsp_exception;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic f; logic [7:0] fn; logic [15:0] a; logic [2:0] n;
    logic [79:0] w; logic [7:0] e; logic [2:0] rn; logic [79:0] r;
  } row_t;
  row_t        rows[$];
  logic        clk, sys_rst, req_valid, req_front_port, wdata_valid;
  logic        rsp_valid, rdata_valid, busy;
  logic [7:0]  req_function, rsp_exception, exc;
  logic [15:0] req_addr, wdata, rdata, error_code;
  logic [2:0]  req_count, active_primary;
  logic [79:0] rd;
  int          fail_count, checked, cycles;
  flame_channel_modbus_register_bank u_dut (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_front_port(req_front_port),
    .req_function(req_function), .req_addr(req_addr), .req_count(req_count),
    .wdata_valid(wdata_valid), .wdata(wdata), .rsp_valid(rsp_valid),
    .rsp_exception(rsp_exception), .rdata_valid(rdata_valid), .rdata(rdata),
    .busy(busy), .active_primary(active_primary), .error_code(error_code));
  modbus_master u_master (.clk(clk), .rsp_valid(rsp_valid),
    .rsp_exception(rsp_exception), .rdata_valid(rdata_valid), .rdata(rdata),
    .req_valid(req_valid), .req_front_port(req_front_port),
    .req_function(req_function), .req_addr(req_addr), .req_count(req_count),
    .wdata_valid(wdata_valid), .wdata(wdata));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic add(input row_t r);
    rows.push_back(r);
  endtask
  task automatic rd_front(input logic [15:0] a, input logic [2:0] n);
    u_master.xfer(1'b1, 8'h03, a, n, 80'h0, 1'b0, exc, rd);
  endtask
  initial begin
    sys_rst = 1'b1;
    add({1'b0, 8'h06, 16'h9c85, 3'h1, 80'h00ff, 8'h00, 3'h1, 80'h00f0});
    add({1'b0, 8'h06, 16'h9c88, 3'h1, 80'h0064, 8'h00, 3'h1, 80'h0064});
    add({1'b0, 8'h06, 16'h9c89, 3'h1, 80'h0065, 8'h03, 3'h1, 80'h0});
    add({1'b0, 8'h06, 16'h9c8d, 3'h1, 80'h0bb7, 8'h00, 3'h1, 80'h0bb7});
    add({1'b0, 8'h10, 16'h9c8b, 3'h5, 80'h0021_0012_0007_0bb8_0005,
      8'h03, 3'h5, 80'h0000_0000_0bb7_0000_0005});
    add({1'b0, 8'h10, 16'h9c8e, 3'h2, 80'hff21_1234, 8'h00, 3'h2,
      80'h0021_0034});
    add({1'b0, 8'h10, 16'h9c91, 3'h2, 80'h0003_00f5, 8'h00, 3'h2,
      80'h0003_0005});
    add({1'b0, 8'h06, 16'h9c95, 3'h1, 80'h0013, 8'h02, 3'h1, 80'h0});
    add({1'b1, 8'h06, 16'h9c95, 3'h1, 80'h0013, 8'h00, 3'h1, 80'h0013});
    add({1'b0, 8'h06, 16'h9c97, 3'h1, 80'h0005, 8'h02, 3'h1, 80'h0001});
    add({1'b1, 8'h10, 16'h9c96, 3'h2, 80'h0009_0002, 8'h00, 3'h2,
      80'h0009_0002});
    add({1'b0, 8'h06, 16'h9c93, 3'h1, 80'h0000, 8'h00, 3'h1, 80'h0});
    add({1'b1, 8'h06, 16'h9c93, 3'h1, 80'h0010, 8'h02, 3'h1, 80'h0});
    add({1'b0, 8'h10, 16'h9c87, 3'h6, 80'h00f0_00f0_00f0_00f0_00f0,
      8'h03, 3'h1, 80'h0});
    add({1'b0, 8'h04, 16'h9c85, 3'h1, 80'h0, 8'h01, 3'h0, 80'h0});
    add({1'b0, 8'h10, 16'h9c85, 3'h0, 80'h0, 8'h03, 3'h0, 80'h0});
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Each row sends its request, then reads back from the front port when rn is nonzero
    foreach (rows[i]) begin
      u_master.xfer(rows[i].f, rows[i].fn, rows[i].a, rows[i].n, rows[i].w,
        i[0], exc, rd);
      chk(exc, rows[i].e);
      if (rows[i].rn != 3'h0) rd_front(rows[i].a, rows[i].rn);
      if (rows[i].rn != 3'h0) chk(rd, rows[i].r);
    end
    chk(active_primary, 3'b000);
    chk(error_code, 16'h0003);
    u_master.xfer(1'b0, 8'h03, 16'h9c90, 3'h1, 80'h0, 1'b0, exc, rd);
    chk(exc, 8'h02);
    chk(rd, 80'h0);
    // Factory key from the front port restores every default except the error code
    u_master.xfer(1'b1, 8'h06, 16'h9c93, 3'h1, 80'h7570, 1'b0, exc, rd);
    chk(exc, 8'h00);
    rd_front(16'h9c93, 3'h5);
    chk(rd, 80'h0001_0000_0000_0002_0070);
    rd_front(16'h9c88, 3'h3);
    chk(rd, 80'h0);
    chk(active_primary, 3'b111);
    u_master.xfer(1'b0, 8'h06, 16'h9c93, 3'h1, 80'h0, 1'b0, exc, rd);
    chk(exc, 8'h00);
    chk(active_primary, 3'b000);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(active_primary, 3'b111);
    stop_test();
  end
endmodule
`default_nettype wire

// [hdl/flame_bank_map.vh]
`ifndef FLAME_BANK_MAP_VH
`define FLAME_BANK_MAP_VH
// Register offsets (Modbus register numbers as 16-bit words)
`define REG_A_HEAD        16'h9c85
`define REG_B_HEAD        16'h9c86
`define REG_C_HEAD        16'h9c87
`define REG_A_GAIN        16'h9c88
`define REG_B_GAIN        16'h9c89
`define REG_C_GAIN        16'h9c8a
`define REG_A_ALARM       16'h9c8b
`define REG_B_ALARM       16'h9c8c
`define REG_C_ALARM       16'h9c8d
`define REG_AB_DELAY      16'h9c8e
`define REG_AB_CHAN_AB_ALT_FAILURE_RESPONSE       16'h9c8f
`define REG_C_DELAY       16'h9c91
`define REG_C_CHAN_AB_ALT_FAILURE_RESPONSE        16'h9c92
`define REG_SWITCH        16'h9c93
`define REG_ERROR         16'h9c94
`define REG_BAUD          16'h9c95
`define REG_PARITY        16'h9c96
`define REG_SLAVE_ID      16'h9c97
// Field layouts
`define HEAD_SEL_MASK     16'h00f0
`define SWITCH_MASK       16'h0070
`define NIBBLE_PAIR_MASK  16'h00ff
`define NIBBLE_MASK       16'h000f
`define BYTE_MASK         16'h00ff
`define SW_BIT_A          4
`define SW_BIT_C          6
// Limits
`define GAIN_MAX          16'h0064
`define ALARM_MAX         16'h0bb7
`define FACTORY_KEY       16'h7570
`define MULTI_MAX         3'h5
// Function codes
`define FN_READ           8'h03
`define FN_WRITE_ONE      8'h06
`define FN_WRITE_MULTI    8'h10
// Exception codes
`define EXC_NONE          8'h00
`define EXC_FUNCTION      8'h01
`define EXC_ADDRESS       8'h02
`define EXC_VALUE         8'h03
// Reset values
`define RST_HEAD          16'h0000
`define RST_GAIN          16'h0000
`define RST_ALARM         16'h0000
`define RST_TIMES         16'h0000
`define RST_SWITCH        16'h0070
`define RST_BAUD          16'h0000
`define RST_PARITY        16'h0000
`define RST_SLAVE_ID      16'h0001
`endif

// [hdl/flame_channel_modbus_register_bank.v]
`timescale 1ns/1ps
`default_nettype none
`include "flame_bank_map.vh"
// Notes on behaviour
// - Head select: bits 5:4 viewing head, bit 6 IR, bit 7 UV.
// - Per-channel analog gain kept, accepted only from 0 to 100.
// - Per-channel alarm level kept, accepted only from 0 to 2999.
// - One register holds delay seconds: A low nibble, B next nibble.
// - One register holds failure response: A low, B upper nibble.
// - Channel C delay and failure response each own a register.
// - Switch bits 4..6 pick set for A..C; one primary, zero alternate.
// - Switch readable on both ports, writable only from four-wire port.
// - Writing 30064 from the front port reloads all defaults except the error code.
// - Error code tracks the four-wire port only; both ports read it.
// - Baud register writable only from the front port; both ports read it.
// - Parity and slave address writable only from the front port; both ports read them.
// - Only functions 03, 06, 16; multiple write up to five registers.
// - Multi write stores values before first bad one, then excepts.
module flame_channel_modbus_register_bank (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        req_valid,
  input  wire        req_front_port,
  input  wire [7:0]  req_function,
  input  wire [15:0] req_addr,
  input  wire [2:0]  req_count,
  input  wire        wdata_valid,
  input  wire [15:0] wdata,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_exception,
  output reg         rdata_valid,
  output reg  [15:0] rdata,
  output reg         busy,
  output reg  [2:0]  active_primary,
  output reg  [15:0] error_code
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_DRAIN = 2'h3;

  reg [1:0]  state;
  reg        front;
  reg [15:0] addr;
  reg [2:0]  left;
  reg [7:0]  exc;
  reg [15:0] regs [0:18];
  reg [15:0] next_rd;
  reg        next_hit;
  reg [4:0]  idx;

  wire [15:0] chk_addr;
  wire [15:0] chk_value;
  wire        mapped;
  wire        port_ok;
  wire        range_ok;
  wire [15:0] keep_mask;
  wire        in_range;
  integer     i;

  // Index of a mapped offset in the storage array
  function [4:0] reg_index;
    input [15:0] a;
    begin
      reg_index = a[4:0] - 5'h05;
    end
  endfunction

  // Reset value for each array slot
  function [15:0] reset_value;
    input [4:0] k;
    begin
      if (k <= 5'h02) reset_value = `RST_HEAD;
      else if (k <= 5'h05) reset_value = `RST_GAIN;
      else if (k <= 5'h08) reset_value = `RST_ALARM;
      else if (k == 5'h0e) reset_value = `RST_SWITCH;
      else if (k == 5'h10) reset_value = `RST_BAUD;
      else if (k == 5'h11) reset_value = `RST_PARITY;
      else if (k == 5'h12) reset_value = `RST_SLAVE_ID;
      else reset_value = `RST_TIMES;
    end
  endfunction

  assign chk_addr  = (state == ST_IDLE) ? req_addr : addr;
  assign chk_value = wdata;
  assign in_range  = (state == ST_IDLE) ? (req_count <= `MULTI_MAX) : 1'b1;

  flame_reg_check u_check (
    .addr       (chk_addr),
    .value      (chk_value),
    .front_port ((state == ST_IDLE) ? req_front_port : front),
    .mapped     (mapped),
    .port_ok    (port_ok),
    .range_ok   (range_ok),
    .keep_mask  (keep_mask)
  );

  // Read mux; error code is served from its own flop
  always @* begin
    idx      = reg_index(addr);
    next_hit = mapped;
    next_rd  = 16'h0000;
    if (addr == `REG_ERROR) next_rd = error_code;
    else if (mapped) next_rd = regs[idx] & keep_mask;
  end

  // Transaction engine: one word per cycle on reads and writes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      front          <= 1'b0;
      addr           <= 16'h0000;
      left           <= 3'h0;
      exc            <= `EXC_NONE;
      rsp_valid      <= 1'b0;
      rsp_exception  <= `EXC_NONE;
      rdata_valid    <= 1'b0;
      rdata          <= 16'h0000;
      busy           <= 1'b0;
      active_primary <= 3'h7;
      error_code     <= 16'h0000;
      for (i = 0; i < 19; i = i + 1) regs[i] <= reset_value(i[4:0]);
    end else begin
      rsp_valid   <= 1'b0;
      rdata_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            front <= req_front_port;
            addr  <= req_addr;
            exc   <= `EXC_NONE;
            busy  <= 1'b1;
            if (req_function == `FN_READ) begin
              left  <= (req_count == 3'h0) ? 3'h1 : req_count;
              state <= ST_READ;
            end else if (req_function == `FN_WRITE_ONE) begin
              left  <= 3'h1;
              state <= ST_WRITE;
            end else if (req_function == `FN_WRITE_MULTI && in_range &&
                         req_count != 3'h0) begin
              left  <= req_count;
              state <= ST_WRITE;
            end else begin
              // Unsupported code, zero or too many words: answer at once
              rsp_valid     <= 1'b1;
              rsp_exception <= (req_function == `FN_WRITE_MULTI) ?
                               `EXC_VALUE : `EXC_FUNCTION;
              // An oversize write still owes its words, so stay busy
              busy          <= (req_function == `FN_WRITE_MULTI &&
                                req_count != 3'h0);
              if (!req_front_port) begin
                error_code <= {8'h00, (req_function == `FN_WRITE_MULTI) ?
                               `EXC_VALUE : `EXC_FUNCTION};
              end
              if (req_function == `FN_WRITE_MULTI && req_count != 3'h0)
                state <= ST_DRAIN;
              left <= req_count;
            end
          end
        end
        ST_READ: begin
          rdata_valid <= 1'b1;
          rdata       <= next_rd;
          if (!next_hit && exc == `EXC_NONE) exc <= `EXC_ADDRESS;
          addr <= addr + 16'h0001;
          left <= left - 3'h1;
          if (left == 3'h1) begin
            rsp_valid     <= 1'b1;
            rsp_exception <= next_hit ? exc : `EXC_ADDRESS;
            if (!front) error_code <= {8'h00, next_hit ? exc : `EXC_ADDRESS};
            busy  <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_WRITE, ST_DRAIN: begin
          if (wdata_valid) begin
            if (state == ST_WRITE && exc == `EXC_NONE) begin
              if (!mapped) begin
                exc <= `EXC_ADDRESS;
              end else if (!range_ok) begin
                exc <= `EXC_VALUE;
              end else if (!port_ok) begin
                exc <= `EXC_ADDRESS;
              end else if (addr == `REG_SWITCH && front) begin
                // Factory key: reload every stored register, switch included; error code kept
                for (i = 0; i < 19; i = i + 1)
                  regs[i] <= reset_value(i[4:0]);
                active_primary <= 3'h7;
              end else begin
                regs[idx] <= wdata & keep_mask;
                if (addr == `REG_SWITCH) begin
                  active_primary <= wdata[`SW_BIT_C:`SW_BIT_A];
                end
              end
            end
            addr <= addr + 16'h0001;
            left <= left - 3'h1;
            if (left == 3'h1) begin
              // Report the first fault; later words were discarded
              rsp_valid     <= (state == ST_WRITE);
              if (state == ST_WRITE) begin
                // A drained message keeps its earlier refusal code
                rsp_exception <= (!mapped || !range_ok || !port_ok) &&
                                 exc == `EXC_NONE ?
                                 (!mapped ? `EXC_ADDRESS :
                                  !range_ok ? `EXC_VALUE : `EXC_ADDRESS) :
                                 exc;
              end
              if (!front && state == ST_WRITE) begin
                error_code <= {8'h00, (!mapped || !range_ok || !port_ok) &&
                               exc == `EXC_NONE ?
                               (!mapped ? `EXC_ADDRESS :
                                !range_ok ? `EXC_VALUE : `EXC_ADDRESS) :
                               exc};
              end
              busy  <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hdl/flame_reg_check.v]
`timescale 1ns/1ps
`default_nettype none
`include "flame_bank_map.vh"
// Combinational map lookup: is the address mapped, may this port write it,
// is the value in range, and which bits are kept.
module flame_reg_check (
  input  wire [15:0] addr,
  input  wire [15:0] value,
  input  wire        front_port,
  output reg         mapped,
  output reg         port_ok,
  output reg         range_ok,
  output reg  [15:0] keep_mask
);
  // Decode address into its policy
  always @* begin
    mapped    = 1'b1;
    port_ok   = 1'b1;
    range_ok  = 1'b1;
    keep_mask = 16'hffff;
    if (addr >= `REG_A_HEAD && addr <= `REG_C_HEAD) begin
      keep_mask = `HEAD_SEL_MASK;
    end else if (addr >= `REG_A_GAIN && addr <= `REG_C_GAIN) begin
      range_ok = (value <= `GAIN_MAX);
    end else if (addr >= `REG_A_ALARM && addr <= `REG_C_ALARM) begin
      range_ok = (value <= `ALARM_MAX);
    end else if (addr == `REG_AB_DELAY || addr == `REG_AB_CHAN_AB_ALT_FAILURE_RESPONSE) begin
      keep_mask = `NIBBLE_PAIR_MASK;
    end else if (addr == `REG_C_DELAY || addr == `REG_C_CHAN_AB_ALT_FAILURE_RESPONSE) begin
      keep_mask = `NIBBLE_MASK;
    end else if (addr == `REG_SWITCH) begin
      keep_mask = `SWITCH_MASK;
      port_ok   = ~front_port | (value == `FACTORY_KEY);
    end else if (addr == `REG_ERROR) begin
      port_ok = 1'b0; // Read only
    end else if (addr >= `REG_BAUD && addr <= `REG_SLAVE_ID) begin
      keep_mask = `BYTE_MASK;
      port_ok   = front_port;
    end else begin
      mapped = 1'b0;
    end
  end
endmodule
`default_nettype wire
